// ==== common/sdf_pkg.sv ====
// Function
// - Referencing by tool ignores reference-approach-start
// - Trial run ignores servo-on, reserves inputs seven/eight
// - Seven force bits, servo-on through quick stop
// - Set force bit holds function at one, except servo-on during trial run
// - Force bit beats any mapped physical input
// - Seven status signals assignable to outputs
// - Ready high only when ready, no fault, enabled
// - Fault output follows fault state, every mode
// - In-position only in position modes, within window
// - Zero speed sets at threshold, clears above hysteresis
// - Speed reached only in speed mode, within range
// - Torque limit reached outside torque mode only
// - Speed limit reached outside torque mode, 10 rpm
package sdf_pkg;
	localparam int N_DI   = 8;
	localparam int N_FUNC = 8;
	localparam int N_DO   = 6;
	localparam int N_FLAG = 7;
	localparam int SEL_W  = 4;

	// Register byte offsets
	localparam logic [7:0] OFS_FORCE      = 8'h00;
	localparam logic [7:0] OFS_FUNC_MAP   = 8'h04;
	localparam logic [7:0] OFS_TOOL_CTRL  = 8'h08;
	localparam logic [7:0] OFS_INP_WIN    = 8'h0c;
	localparam logic [7:0] OFS_ZSP_THR    = 8'h10;
	localparam logic [7:0] OFS_VELOCITY_REACHED_FLAG_RANGE = 8'h14;
	localparam logic [7:0] OFS_DO_SEL     = 8'h18;
	localparam logic [7:0] OFS_FUNC_STATE = 8'h1c;
	localparam logic [7:0] OFS_DO_STATE   = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT   = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h28;

	// Field positions
	localparam int CTRL_REF_BIT   = 0;
	localparam int CTRL_TRIAL_BIT = 1;
	localparam int FST_TOOL_LSB   = 8;
	localparam int FST_DIN_LSB    = 16;
	localparam int DST_PIN_LSB    = 16;

	// Function indices, equal to force mask bit positions except reference approach start (no force bit)
	localparam int FN_SON  = 0;
	localparam int FN_EMERGENCY_QUICK_STOP = 6;
	localparam int FN_REFERENCE_APPROACH_START = 7;

	// Control modes
	localparam logic [1:0] MODE_PTI  = 2'h0;
	localparam logic [1:0] MODE_INTERNAL_POSITION_MODE = 2'h1;
	localparam logic [1:0] MODE_SPD  = 2'h2;
	localparam logic [1:0] MODE_TRQ  = 2'h3;

	// Reset values
	localparam logic [6:0]  FORCE_RST      = 7'h00;
	localparam logic [31:0] FUNC_MAP_RST   = 32'h87654321;
	localparam logic [1:0]  TOOL_CTRL_RST  = 2'h0;
	localparam logic [15:0] INP_WIN_RST    = 16'h0028;
	localparam logic [15:0] ZSP_THR_RST    = 16'h000a;
	localparam logic [15:0] VELOCITY_REACHED_FLAG_RANGE_RST = 16'h000a;
	localparam logic [23:0] DO_SEL_RST     = 24'h654321;

	// Hysteresis bands
	localparam logic [15:0] SPD_HYST_RPM = 16'h000a;
	localparam logic [15:0] TRQ_HYST     = 16'h0010;

	function automatic logic [SEL_W-1:0] sdf_nib(input logic [31:0] w, input int unsigned i);
		return w[i*SEL_W +: SEL_W];
	endfunction

	function automatic logic [16:0] sdf_abs(input logic [16:0] v);
		return v[16] ? 17'(~v + 17'h1) : v;
	endfunction
endpackage

// ==== common/sdf_core_if.sv ====
`timescale 1ns/1ps
interface sdf_core_if;
	import sdf_pkg::*;
	logic [N_DI-1:0]   din;
	logic [6:0]        force_mask;
	logic [31:0]       func_map;
	logic              tool_ref;
	logic              tool_trial;
	logic [N_FUNC-1:0] funcs;
	logic [1:0]        tool_di;
	logic [1:0]        mode;
	logic              fault;
	logic              enable;
	logic              core_ready;
	logic [15:0]       follow_err;
	logic [15:0]       speed_act;
	logic [15:0]       speed_set;
	logic [15:0]       speed_lim;
	logic [15:0]       torque_act;
	logic [15:0]       lim_pos;
	logic [15:0]       lim_neg;
	logic [15:0]       lim_ana;
	logic [15:0]       inp_win;
	logic [15:0]       zsp_thr;
	logic [15:0]       velocity_reached_flag_range;
	logic [N_FLAG-1:0] flags;

	modport top (output din, force_mask, func_map, tool_ref, tool_trial, mode, fault, enable,
		core_ready, follow_err, speed_act, speed_set, speed_lim, torque_act, lim_pos,
		lim_neg, lim_ana, inp_win, zsp_thr, velocity_reached_flag_range, input funcs, tool_di, flags);
	modport fmap (input din, force_mask, func_map, tool_ref, tool_trial, output funcs, tool_di);
	modport stat (input mode, fault, enable, core_ready, follow_err, speed_act, speed_set,
		speed_lim, torque_act, lim_pos, lim_neg, lim_ana, inp_win, zsp_thr, velocity_reached_flag_range,
		output flags);
endinterface

// ==== hw/sdf_force_map.sv ====
`timescale 1ns/1ps
module sdf_force_map
	import sdf_pkg::*;
(
	// Core link
	sdf_core_if.fmap cif
);
	wire [N_FUNC-1:0] phys;

	genvar f;
	generate
		for (f = 0; f < N_FUNC; f++) begin : g_fn
			wire [SEL_W-1:0] sel      = sdf_nib(cif.func_map, f);
			wire             hit      = (sel != 4'h0) && (sel <= 4'(N_DI));
			wire [2:0]       idx      = 3'(sel - 4'h1);
			wire             reserved = cif.tool_trial && (idx >= 3'h6);
			assign phys[f] = hit && !reserved && cif.din[idx];
			if (f == FN_SON) begin : g_son
				assign cif.funcs[f] = !cif.tool_trial && (cif.force_mask[f] || phys[f]);
			end else if (f == FN_REFERENCE_APPROACH_START) begin : g_reference_approach_start
				assign cif.funcs[f] = !cif.tool_ref && phys[f];
			end else begin : g_forced
				assign cif.funcs[f] = cif.force_mask[f] || phys[f];
			end
		end
	endgenerate

	assign cif.tool_di = cif.tool_trial ? cif.din[7:6] : 2'h0;
endmodule

// ==== hw/sdf_status_gen.sv ====
`timescale 1ns/1ps
module sdf_status_gen
	import sdf_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Core link
	sdf_core_if.stat  cif
);
	logic zero_velocity_flag;
	logic velocity_reached_flag;

	wire [16:0] spd_abs  = sdf_abs({cif.speed_act[15], cif.speed_act});
	wire [16:0] trq_abs  = sdf_abs({cif.torque_act[15], cif.torque_act});
	wire [16:0] err_abs  = sdf_abs({cif.follow_err[15], cif.follow_err});
	wire [16:0] diff_abs = sdf_abs({cif.speed_act[15], cif.speed_act}
		- {cif.speed_set[15], cif.speed_set});
	wire [16:0] zsp_hi   = {1'b0, cif.zsp_thr} + {1'b0, SPD_HYST_RPM};
	wire [16:0] velocity_reached_flag_hi  = {1'b0, cif.velocity_reached_flag_range} + {1'b0, SPD_HYST_RPM};
	wire [16:0] trq_near = trq_abs + {1'b0, TRQ_HYST};
	wire [16:0] spd_near = spd_abs + {1'b0, SPD_HYST_RPM};
	wire        pos_mode = (cif.mode == MODE_PTI) || (cif.mode == MODE_INTERNAL_POSITION_MODE);
	wire        trq_lim  = (!cif.torque_act[15] && trq_near >= {1'b0, cif.lim_pos})
		|| (cif.torque_act[15] && trq_near >= {1'b0, cif.lim_neg})
		|| (trq_near >= {1'b0, cif.lim_ana});

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			zero_velocity_flag <= 1'b0;
		end else if (spd_abs <= {1'b0, cif.zsp_thr}) begin
			zero_velocity_flag <= 1'b1;
		end else if (spd_abs > zsp_hi) begin
			zero_velocity_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			velocity_reached_flag <= 1'b0;
		end else if (diff_abs <= {1'b0, cif.velocity_reached_flag_range}) begin
			velocity_reached_flag <= 1'b1;
		end else if (diff_abs > velocity_reached_flag_hi) begin
			velocity_reached_flag <= 1'b0;
		end
	end

	assign cif.flags[0] = cif.core_ready && !cif.fault && cif.enable;
	assign cif.flags[1] = cif.fault;
	assign cif.flags[2] = pos_mode && (err_abs <= {1'b0, cif.inp_win});
	assign cif.flags[3] = zero_velocity_flag;
	assign cif.flags[4] = (cif.mode == MODE_SPD) && velocity_reached_flag;
	assign cif.flags[5] = (cif.mode != MODE_TRQ) && trq_lim;
	assign cif.flags[6] = (cif.mode != MODE_TRQ) && (spd_near >= {1'b0, cif.speed_lim});
endmodule

// ==== hw/sdf_top.sv ====
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module sdf_top
	import sdf_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// Register bus
	input  wire logic [7:0]        bus_addr,
	input  wire logic [31:0]       bus_wdata,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	output logic      [31:0]       bus_rdata,
	// Digital input pins
	input  wire logic [N_DI-1:0]   din_pin,
	// Drive core state
	input  wire logic [1:0]        drv_mode,
	input  wire logic              drv_fault,
	input  wire logic              drv_enable,
	input  wire logic              drv_core_ready,
	input  wire logic [15:0]       drv_follow_err,
	input  wire logic [15:0]       drv_speed_act,
	input  wire logic [15:0]       drv_speed_set,
	input  wire logic [15:0]       drv_speed_lim,
	input  wire logic [15:0]       drv_torque_act,
	input  wire logic [15:0]       drv_lim_pos,
	input  wire logic [15:0]       drv_lim_neg,
	input  wire logic [15:0]       drv_lim_ana,
	// Resolved input functions
	output logic      [N_FUNC-1:0] func_out,
	output logic      [1:0]        tool_di_out,
	// Digital output pins
	output logic      [N_DO-1:0]   do_pin,
	// Interrupt
	output logic                   irq
);
	////////////////////////////////////////////////////////////////////////////
	// Input pin synchroniser

	logic [N_DI-1:0] din_meta;
	logic [N_DI-1:0] din_sync;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			din_meta <= '0;
			din_sync <= '0;
		end else begin
			din_meta <= din_pin;
			din_sync <= din_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [6:0]        force_mask;
	logic [31:0]       func_map;
	logic [1:0]        tool_ctrl;
	logic [15:0]       inp_win;
	logic [15:0]       zsp_thr;
	logic [15:0]       velocity_reached_flag_range;
	logic [23:0]       do_sel;
	logic [N_FLAG-1:0] irq_stat;
	logic [N_FLAG-1:0] irq_mask;
	logic [N_FLAG-1:0] flags_q;

	wire wr_force  = bus_wr && (bus_addr == OFS_FORCE);
	wire wr_map    = bus_wr && (bus_addr == OFS_FUNC_MAP);
	wire wr_ctrl   = bus_wr && (bus_addr == OFS_TOOL_CTRL);
	wire wr_inp    = bus_wr && (bus_addr == OFS_INP_WIN);
	wire wr_zsp    = bus_wr && (bus_addr == OFS_ZSP_THR);
	wire wr_velocity_reached_flag   = bus_wr && (bus_addr == OFS_VELOCITY_REACHED_FLAG_RANGE);
	wire wr_do_sel = bus_wr && (bus_addr == OFS_DO_SEL);
	wire wr_istat  = bus_wr && (bus_addr == OFS_IRQ_STAT);
	wire wr_imask  = bus_wr && (bus_addr == OFS_IRQ_MASK);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			force_mask <= FORCE_RST;
		end else if (wr_force) begin
			force_mask <= bus_wdata[6:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			func_map <= FUNC_MAP_RST;
		end else if (wr_map) begin
			func_map <= bus_wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tool_ctrl <= TOOL_CTRL_RST;
		end else if (wr_ctrl) begin
			tool_ctrl <= bus_wdata[1:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			inp_win <= INP_WIN_RST;
		end else if (wr_inp) begin
			inp_win <= bus_wdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			zsp_thr <= ZSP_THR_RST;
		end else if (wr_zsp) begin
			zsp_thr <= bus_wdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			velocity_reached_flag_range <= VELOCITY_REACHED_FLAG_RANGE_RST;
		end else if (wr_velocity_reached_flag) begin
			velocity_reached_flag_range <= bus_wdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			do_sel <= DO_SEL_RST;
		end else if (wr_do_sel) begin
			do_sel <= bus_wdata[23:0];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask <= '0;
		end else if (wr_imask) begin
			irq_mask <= bus_wdata[N_FLAG-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Force, mapping and status cores

	sdf_core_if cif ();

	assign cif.din        = din_sync;
	assign cif.force_mask = force_mask;
	assign cif.func_map   = func_map;
	assign cif.tool_ref   = tool_ctrl[CTRL_REF_BIT];
	assign cif.tool_trial = tool_ctrl[CTRL_TRIAL_BIT];
	assign cif.mode       = drv_mode;
	assign cif.fault      = drv_fault;
	assign cif.enable     = drv_enable;
	assign cif.core_ready = drv_core_ready;
	assign cif.follow_err = drv_follow_err;
	assign cif.speed_act  = drv_speed_act;
	assign cif.speed_set  = drv_speed_set;
	assign cif.speed_lim  = drv_speed_lim;
	assign cif.torque_act = drv_torque_act;
	assign cif.lim_pos    = drv_lim_pos;
	assign cif.lim_neg    = drv_lim_neg;
	assign cif.lim_ana    = drv_lim_ana;
	assign cif.inp_win    = inp_win;
	assign cif.zsp_thr    = zsp_thr;
	assign cif.velocity_reached_flag_range = velocity_reached_flag_range;

	sdf_force_map u_force_map (
		.cif (cif.fmap)
	);

	sdf_status_gen u_status_gen (
		.clk    (clk),
		.arst_n (arst_n),
		.cif    (cif.stat)
	);

	////////////////////////////////////////////////////////////////////////////
	// Registered functions towards the drive core

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			func_out    <= '0;
			tool_di_out <= 2'h0;
		end else begin
			func_out    <= cif.funcs;
			tool_di_out <= cif.tool_di;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output signal routing

	// Code 0 is off, codes 1..7 the flags, codes 8..15 read as zero
	wire [15:0] sig_vec = {8'h00, flags_q, 1'b0};

	genvar d;
	generate
		for (d = 0; d < N_DO; d++) begin : g_do
			wire [SEL_W-1:0] sel = sdf_nib({8'h00, do_sel}, d);
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					do_pin[d] <= 1'b0;
				end else begin
					do_pin[d] <= sig_vec[sel];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Interrupts

	wire [N_FLAG-1:0] flag_rise      = cif.flags & ~flags_q;
	wire [N_FLAG-1:0] istat_clr      = wr_istat ? bus_wdata[N_FLAG-1:0] : '0;
	// Set beats a simultaneous clear
	wire [N_FLAG-1:0] next_irq_stat  = (irq_stat & ~istat_clr) | flag_rise;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_q  <= '0;
			irq_stat <= '0;
			irq      <= 1'b0;
		end else begin
			flags_q  <= cif.flags;
			irq_stat <= next_irq_stat;
			irq      <= |(next_irq_stat & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read back

	wire [31:0] func_state = {8'h00, din_sync, 6'h00, tool_di_out, func_out};
	wire [31:0] do_state   = {10'h000, do_pin, sig_vec};

	logic [31:0] rd_mux;

	always_comb begin
		unique case (bus_addr)
			OFS_FORCE:      rd_mux = {25'h0, force_mask};
			OFS_FUNC_MAP:   rd_mux = func_map;
			OFS_TOOL_CTRL:  rd_mux = {30'h0, tool_ctrl};
			OFS_INP_WIN:    rd_mux = {16'h0, inp_win};
			OFS_ZSP_THR:    rd_mux = {16'h0, zsp_thr};
			OFS_VELOCITY_REACHED_FLAG_RANGE: rd_mux = {16'h0, velocity_reached_flag_range};
			OFS_DO_SEL:     rd_mux = {8'h00, do_sel};
			OFS_FUNC_STATE: rd_mux = func_state;
			OFS_DO_STATE:   rd_mux = do_state;
			OFS_IRQ_STAT:   rd_mux = {25'h0, irq_stat};
			OFS_IRQ_MASK:   rd_mux = {25'h0, irq_mask};
			default:        rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_rdata <= 32'h0;
		end else begin
			bus_rdata <= bus_rd ? rd_mux : 32'h0;
		end
	end
endmodule

// ==== bench/sdf_props.sv ====
`timescale 1ns/1ps
module sdf_props
	import sdf_pkg::*;
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              arst_n,
	// Register bus
	input wire logic [7:0]        bus_addr,
	input wire logic [31:0]       bus_wdata,
	input wire logic              bus_wr,
	input wire logic              bus_rd,
	input wire logic [31:0]       bus_rdata,
	// Drive core state
	input wire logic [1:0]        drv_mode,
	input wire logic              drv_fault,
	input wire logic              drv_enable,
	input wire logic              drv_core_ready,
	// Outputs
	input wire logic [N_FUNC-1:0] func_out,
	input wire logic [1:0]        tool_di_out,
	input wire logic [N_DO-1:0]   do_pin
);
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// Shadow of the registers the outputs depend on
	logic [6:0] frc;
	logic [1:0] ctl;
	logic       dflt;
	wire        w_frc = bus_wr && bus_addr == OFS_FORCE;
	wire        w_ctl = bus_wr && bus_addr == OFS_TOOL_CTRL;
	wire        w_sel = bus_wr && bus_addr == OFS_DO_SEL;
	wire        son_f = frc[0] && !ctl[CTRL_TRIAL_BIT];
	wire        rdy   = drv_core_ready && !drv_fault && drv_enable;
	wire        nspd  = drv_mode != MODE_SPD;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			frc  <= FORCE_RST;
			ctl  <= TOOL_CTRL_RST;
			dflt <= 1'b1;
		end else begin
			if (w_frc)
				frc <= bus_wdata[6:0];
			if (w_ctl)
				ctl <= bus_wdata[1:0];
			if (w_sel)
				dflt <= bus_wdata[23:0] == DO_SEL_RST;
		end
	end

	////////////////////////////////////////
	rdata_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
		else $error("read data outside the answer cycle");
	force_hold_a: assert property (($past(frc[6:1]) & ~func_out[6:1]) == 6'h0)
		else $error("forced function not high");
	servo_force_a: assert property ($past(son_f) |-> func_out[FN_SON])
		else $error("forced servo on not high");
	trial_servo_a: assert property ($past(ctl[CTRL_TRIAL_BIT]) |-> !func_out[FN_SON])
		else $error("servo on passed during trial");
	tool_idle_a: assert property (!$past(ctl[CTRL_TRIAL_BIT]) |-> tool_di_out == 2'h0)
		else $error("tool inputs outside trial");
	ref_skip_a: assert property ($past(ctl[CTRL_REF_BIT]) |-> !func_out[FN_REFERENCE_APPROACH_START])
		else $error("approach start passed while referencing");
	ready_map_a: assert property ($past(dflt) |-> do_pin[0] == $past(rdy, 2))
		else $error("ready output wrong");
	fault_map_a: assert property ($past(dflt) |-> do_pin[1] == $past(drv_fault, 2))
		else $error("fault output wrong");
	inpos_mode_a: assert property ($past(dflt) && $past(drv_mode, 2) > 2'h1 |-> !do_pin[2])
		else $error("in position outside position modes");
	reach_mode_a: assert property ($past(dflt) && $past(nspd, 2) && $past(nspd, 3) |-> !do_pin[4])
		else $error("speed reached outside speed mode");
	trq_mode_a: assert property ($past(dflt) && $past(drv_mode, 2) == MODE_TRQ |-> !do_pin[5])
		else $error("torque limit flag in torque mode");

	cover property (w_frc);
	cover property (ctl[CTRL_TRIAL_BIT] && tool_di_out != 2'h0);
	cover property ($rose(do_pin[3]));
endmodule

bind sdf_top sdf_props u_props (
	.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_rdata(bus_rdata), .drv_mode(drv_mode), .drv_fault(drv_fault),
	.drv_enable(drv_enable), .drv_core_ready(drv_core_ready), .func_out(func_out),
	.tool_di_out(tool_di_out), .do_pin(do_pin)
);

// ==== bench/sdf_ctrl_model.sv ====
`timescale 1ns/1ps
module sdf_ctrl_model
	import sdf_pkg::*;
(
	// Clock
	input  wire logic            clk,
	// Contact levels asked by the bench
	input  wire logic [N_DI-1:0] want,
	// Device pins
	input  wire logic [N_DO-1:0] do_pin,
	output logic      [N_DI-1:0] din_pin,
	output logic      [N_DO-1:0] do_seen
);
	initial din_pin = '0;

	// Contacts switch after an edge, outputs are read on it
	always @(posedge clk) begin
		din_pin <= want;
		do_seen <= do_pin;
	end
endmodule

// ==== bench/sdf_tb_top.sv ====
`timescale 1ns/1ps
module sdf_tb_top
	import sdf_pkg::*;
;
	typedef struct packed {
		logic [1:0]   mode;
		logic [2:0]   fer;
		logic [127:0] vals;
		logic [6:0]   exp;
	} sdf_row_s;

	localparam sdf_row_s ROWS [5] = '{
		'{2'h0, 3'h3, {16'h0028, 16'h0000, 16'h0000, 16'h03e8,
			16'h0000, 16'h03e8, 16'h03e8, 16'h03e8}, 7'h0d},
		'{2'h1, 3'h7, {16'hffd7, 16'hfe0c, 16'h0000, 16'h01fe,
			16'h03de, 16'h03e8, 16'h03e8, 16'h07d0}, 7'h62},
		'{2'h2, 3'h1, {16'h0000, 16'h012c, 16'h0136, 16'h03e8,
			16'hfc27, 16'h0064, 16'h03e8, 16'h07d0}, 7'h30},
		'{2'h3, 3'h3, {16'h0000, 16'h0005, 16'h012c, 16'h0005,
			16'h07d0, 16'h0064, 16'h0064, 16'h0064}, 7'h09},
		'{2'h2, 3'h2, {16'h0000, 16'h0064, 16'h007d, 16'h03e8,
			16'h0032, 16'h03e8, 16'h03e8, 16'h003c}, 7'h20}};
	localparam logic [15:0] ZS [5] = '{16'h000a, 16'h0014, 16'h0015, 16'h0014, 16'hfff6};
	localparam logic [4:0]  ZE = 5'b10011;
	localparam logic [7:0]  RA [9] = '{OFS_FORCE, OFS_FUNC_MAP, OFS_TOOL_CTRL, OFS_INP_WIN,
		OFS_ZSP_THR, OFS_VELOCITY_REACHED_FLAG_RANGE, OFS_DO_SEL, OFS_IRQ_MASK, 8'h30};
	localparam logic [31:0] RV [9] = '{32'(FORCE_RST), FUNC_MAP_RST, 32'(TOOL_CTRL_RST),
		32'(INP_WIN_RST), 32'(ZSP_THR_RST), 32'(VELOCITY_REACHED_FLAG_RANGE_RST), 32'(DO_SEL_RST), 32'h0, 32'h0};

	logic              clk = 1'b0;
	logic              arst_n = 1'b0;
	logic [7:0]        bus_addr = 8'h00;
	logic [31:0]       bus_wdata = 32'h0;
	logic              bus_wr = 1'b0;
	logic              bus_rd = 1'b0;
	logic [31:0]       bus_rdata;
	logic [31:0]       rd_d;
	logic [N_DI-1:0]   din_pin;
	logic [N_DI-1:0]   want = '0;
	logic [1:0]        drv_mode = 2'h0;
	logic              drv_fault = 1'b0;
	logic              drv_enable = 1'b0;
	logic              drv_core_ready = 1'b0;
	logic [127:0]      drv_vals = '0;
	logic [N_FUNC-1:0] func_out;
	logic [1:0]        tool_di_out;
	logic [N_DO-1:0]   do_pin;
	logic [N_DO-1:0]   do_seen;
	logic              irq;
	int                failures = 0;
	int                n_checks = 0;

	always #10 clk = ~clk;

	sdf_top uut (
		.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .din_pin(din_pin),
		.drv_mode(drv_mode), .drv_fault(drv_fault), .drv_enable(drv_enable),
		.drv_core_ready(drv_core_ready), .drv_follow_err(drv_vals[127:112]),
		.drv_speed_act(drv_vals[111:96]), .drv_speed_set(drv_vals[95:80]),
		.drv_speed_lim(drv_vals[79:64]), .drv_torque_act(drv_vals[63:48]),
		.drv_lim_pos(drv_vals[47:32]), .drv_lim_neg(drv_vals[31:16]),
		.drv_lim_ana(drv_vals[15:0]), .func_out(func_out), .tool_di_out(tool_di_out),
		.do_pin(do_pin), .irq(irq));

	sdf_ctrl_model u_ctrl (.clk(clk), .want(want), .do_pin(do_pin), .din_pin(din_pin),
		.do_seen(do_seen));

	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus_wr    <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus_rd   <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		#1 rd_d = bus_rdata;
	endtask

	task automatic drive(input logic [132:0] v);
		@(posedge clk);
		{drv_mode, drv_fault, drv_enable, drv_core_ready, drv_vals} <= v;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic close_out;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		#(20 * 8000);
		failures++;
		close_out();
	end

	initial begin
		wait_n(4);
		arst_n <= 1'b1;
		foreach (ROWS[i]) begin
			drive(ROWS[i][139:7]);
			wait_n(5);
			chk(32'(do_seen), 32'(ROWS[i].exp[5:0]));
			rd(OFS_DO_STATE);
			chk(32'(rd_d[15:1]), 32'(ROWS[i].exp));
		end
		$display("status rows done");
		// Each force bit 0..6 alone raises only its own function
		for (int i = 0; i < 7; i++) begin
			wr(OFS_FORCE, 32'h1 << i);
			wait_n(1);
			chk(32'(func_out), 32'h1 << i);
		end
		wr(OFS_FORCE, 32'h03);
		wait_n(4);
		chk(32'(func_out), 32'h03);
		wr(OFS_FUNC_MAP, 32'h87654310);
		wr(OFS_FORCE, 32'h01);
		want <= 8'h01;
		wait_n(4);
		chk(32'(func_out), 32'h03);
		$display("force done");
		wr(OFS_FUNC_MAP, FUNC_MAP_RST);
		want <= 8'hff;
		wr(OFS_TOOL_CTRL, 32'h2);
		wait_n(4);
		chk(32'(func_out), 32'h3e);
		chk(32'(tool_di_out), 32'h3);
		want <= 8'hbf;
		wait_n(4);
		chk(32'(tool_di_out), 32'h2);
		want <= 8'hff;
		wr(OFS_TOOL_CTRL, 32'h1);
		wait_n(4);
		chk(32'(func_out), 32'h7f);
		wr(OFS_TOOL_CTRL, 32'h0);
		wait_n(2);
		chk(32'(func_out), 32'hff);
		$display("tool modes done");
		foreach (ZS[i]) begin
			@(posedge clk);
			drv_vals[111:96] <= ZS[i];
			wait_n(5);
			chk(32'(do_pin[3]), 32'(ZE[i]));
		end
		$display("zero speed done");
		wr(OFS_IRQ_STAT, 32'h7f);
		wr(OFS_IRQ_MASK, 32'h02);
		@(posedge clk);
		drv_fault <= 1'b1;
		wait_n(4);
		chk(32'(irq), 32'h1);
		wr(OFS_IRQ_MASK, 32'h0);
		wait_n(2);
		chk(32'(irq), 32'h0);
		wr(OFS_IRQ_MASK, 32'h02);
		wait_n(2);
		chk(32'(irq), 32'h1);
		wr(OFS_IRQ_STAT, 32'h02);
		wait_n(2);
		chk(32'(irq), 32'h0);
		$display("interrupt done");
		wr(OFS_DO_SEL, 32'h654370);
		for (int i = 1; i >= 0; i--) begin
			drive(ROWS[i][139:7]);
			wait_n(5);
			chk(32'(do_pin[1:0]), 32'(i * 2));
		end
		wr(OFS_DO_SEL, 32'(DO_SEL_RST));
		$display("output select done");
		wr(OFS_FORCE, 32'h0);
		want <= 8'h00;
		drive(133'h0);
		wait_n(6);
		foreach (RA[i])
			wr(RA[i], 32'h5a5a5a5a);
		rd(8'h30);
		chk(rd_d, 32'h0);
		@(posedge clk);
		arst_n <= 1'b0;
		wait_n(4);
		chk(32'(func_out), 32'h0);
		chk(32'({do_pin, irq, tool_di_out}), 32'h0);
		chk(bus_rdata, 32'h0);
		arst_n <= 1'b1;
		foreach (RA[i]) begin
			rd(RA[i]);
			chk(rd_d, RV[i]);
		end
		$display("reset done");
		close_out();
	end
endmodule
